/* rtl/key_id_process_image_defs.svh */
`ifndef KEY_ID_PROCESS_IMAGE_DEFS_SVH
`define KEY_ID_PROCESS_IMAGE_DEFS_SVH

// Register byte offsets
`define KIP_ADR_KEY_LO 8'h00
`define KIP_ADR_KEY_HI 8'h04
`define KIP_ADR_HEAD 8'h08
`define KIP_ADR_IRQ_STAT 8'h0C
`define KIP_ADR_IRQ_EN 8'h10
`define KIP_ADR_IRQ_CLR 8'h14

// Field positions
`define KIP_STAT_LINK_FAULT 0
`define KIP_HEAD_CMD_LSB 16
`define KIP_EV_KEY_IN 0
`define KIP_EV_KEY_OUT 1
`define KIP_EV_FAULT 2
`define KIP_EV_CMD 3
`define KIP_EV_W 4

// Override command values
`define KIP_CMD_RED 8'h01
`define KIP_CMD_GREEN 8'h02

// Reset values
`define KIP_RST_CMD 8'h00
`define KIP_RST_IRQ_EN 4'h0

// Timing
`define KIP_CLK_HZ 20000000
`define KIP_HEAD_BLINK_HZ 1
`define KIP_BLINK_HALF (`KIP_CLK_HZ / (2 * `KIP_HEAD_BLINK_HZ))

`endif

/* rtl/key_id_process_image_pkg.sv */
package key_id_process_image_pkg;

    // Source of the reading-head lamp
    typedef enum logic [1:0] {HEAD_OWN, HEAD_RED, HEAD_GREEN, HEAD_FAULT} headSel_t;

    // Network state behind the bus-state indicator
    typedef enum logic [1:0] {BUS_OFFLINE, BUS_IDLE, BUS_ACTIVE} busState_t;

endpackage : key_id_process_image_pkg

/* rtl/key_id_process_image.sv */
`timescale 1ns/1ns
`include "key_id_process_image_defs.svh"

module key_id_process_image #(
    parameter int BLINK_HALF = `KIP_BLINK_HALF,
    parameter int CNT_W = 24
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq,
    input wire logic cycleTick,
    input wire logic keyPresent,
    input wire logic keyReadError,
    input wire logic [7:0] keyFamily,
    input wire logic [47:0] keyIdent,
    input wire logic [7:0] keyCheck,
    input wire logic headLinkFault,
    input wire logic cmdValid,
    input wire logic [7:0] headLampOverrideCmd,
    input wire logic netConnected,
    input wire logic arActive,
    output logic [7:0] imgKeyType,
    output logic [47:0] keyIdentByte,
    output logic [7:0] imgKeyCheck,
    output logic [15:0] imgStatus,
    output logic headLedRed,
    output logic headLedGreen,
    output logic busStateIndicatorRed,
    output logic busStateIndicatorGreen
);

    typedef struct packed {
        logic [7:0] keyType;
        logic [47:0] ident;
        logic [7:0] check;
        logic [15:0] status;
        logic [7:0] ledCmd;
        key_id_process_image_pkg::headSel_t headSel;
        key_id_process_image_pkg::busState_t busState;
        logic [CNT_W-1:0] blinkCnt;
        logic blinkPhase;
        logic flashPhase;
        logic headRed;
        logic headGreen;
        logic busRed;
        logic busGreen;
        logic keyPrev;
        logic faultPrev;
        logic [`KIP_EV_W-1:0] irqStat;
        logic [`KIP_EV_W-1:0] irqEn;
        logic irqOut;
        logic ack;
        logic [31:0] rdData;
    } state_t;

    state_t s_r;
    state_t s_nxt;
    logic wbReq;
    logic [`KIP_EV_W-1:0] events;
    logic [`KIP_EV_W-1:0] clrMask;

    assign wbReq = wb_cyc_i & wb_stb_i & ~s_r.ack;

    // Next-state logic for the whole block
    always_comb begin
        s_nxt = s_r;
        events = '0;
        clrMask = '0;

        // Cyclic input image; identifier passed through untouched, no access decision here
        if (cycleTick) begin
            if (keyPresent && !keyReadError) begin
                s_nxt.keyType = keyFamily;
                s_nxt.ident = keyIdent;
                s_nxt.check = keyCheck;
            end else begin
                s_nxt.keyType = 8'h00;
                s_nxt.ident = 48'h000000000000;
                s_nxt.check = 8'h00;
            end
            s_nxt.status = 16'h0000;
            s_nxt.status[`KIP_STAT_LINK_FAULT] = headLinkFault;
        end

        // Output byte from the controller
        if (cmdValid) begin
            s_nxt.ledCmd = headLampOverrideCmd;
            events[`KIP_EV_CMD] = 1'b1;
        end

        // Shared blink timebase, one phase flip per half period
        if (s_r.blinkCnt >= CNT_W'(BLINK_HALF - 1)) begin
            s_nxt.blinkCnt = '0;
            s_nxt.blinkPhase = ~s_r.blinkPhase;
            if (s_r.blinkPhase) begin
                s_nxt.flashPhase = ~s_r.flashPhase;
            end
        end else begin
            s_nxt.blinkCnt = s_r.blinkCnt + CNT_W'(1);
        end

        // Head lamp source selection
        if (headLinkFault) begin
            s_nxt.headSel = key_id_process_image_pkg::HEAD_FAULT;
        end else if (s_r.ledCmd == `KIP_CMD_RED) begin
            s_nxt.headSel = key_id_process_image_pkg::HEAD_RED;
        end else if (s_r.ledCmd == `KIP_CMD_GREEN) begin
            s_nxt.headSel = key_id_process_image_pkg::HEAD_GREEN;
        end else begin
            s_nxt.headSel = key_id_process_image_pkg::HEAD_OWN;
        end

        // Head lamp drive
        case (s_nxt.headSel)
            key_id_process_image_pkg::HEAD_FAULT: begin
                s_nxt.headRed = s_r.blinkPhase; // Orange blink
                s_nxt.headGreen = s_r.blinkPhase;
            end
            key_id_process_image_pkg::HEAD_RED: begin
                s_nxt.headRed = 1'b1;
                s_nxt.headGreen = 1'b0;
            end
            key_id_process_image_pkg::HEAD_GREEN: begin
                s_nxt.headRed = 1'b0;
                s_nxt.headGreen = 1'b1;
            end
            key_id_process_image_pkg::HEAD_OWN: begin
                if (keyPresent && keyReadError) begin
                    s_nxt.headRed = s_r.blinkPhase;
                    s_nxt.headGreen = 1'b0;
                end else if (keyPresent) begin
                    s_nxt.headRed = 1'b0;
                    s_nxt.headGreen = s_r.blinkPhase;
                end else begin
                    s_nxt.headRed = 1'b0;
                    s_nxt.headGreen = s_r.blinkPhase & s_r.flashPhase; // Short flash, idle
                end
            end
            default: begin
                s_nxt.headRed = 1'b0;
                s_nxt.headGreen = 1'b0;
            end
        endcase

        // Bus-state indicator
        if (arActive) begin
            s_nxt.busState = key_id_process_image_pkg::BUS_ACTIVE;
        end else if (netConnected) begin
            s_nxt.busState = key_id_process_image_pkg::BUS_IDLE;
        end else begin
            s_nxt.busState = key_id_process_image_pkg::BUS_OFFLINE;
        end
        case (s_nxt.busState)
            key_id_process_image_pkg::BUS_ACTIVE: begin
                s_nxt.busGreen = 1'b1;
                s_nxt.busRed = 1'b0;
            end
            key_id_process_image_pkg::BUS_IDLE: begin
                s_nxt.busGreen = s_r.blinkPhase;
                s_nxt.busRed = ~s_r.blinkPhase;
            end
            default: begin
                s_nxt.busGreen = 1'b0;
                s_nxt.busRed = 1'b1;
            end
        endcase

        // Event edges
        s_nxt.keyPrev = keyPresent;
        s_nxt.faultPrev = headLinkFault;
        events[`KIP_EV_KEY_IN] = keyPresent & ~s_r.keyPrev;
        events[`KIP_EV_KEY_OUT] = ~keyPresent & s_r.keyPrev;
        events[`KIP_EV_FAULT] = headLinkFault & ~s_r.faultPrev;

        // Wishbone slave, one wait state, ack for every address; a write lands on the edge that sees ack
        s_nxt.ack = wbReq;
        s_nxt.rdData = 32'h00000000;
        if (s_r.ack && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]) begin
            case (wb_adr_i)
                `KIP_ADR_IRQ_EN: s_nxt.irqEn = wb_dat_i[`KIP_EV_W-1:0];
                `KIP_ADR_IRQ_CLR: clrMask = wb_dat_i[`KIP_EV_W-1:0];
                default: ;
            endcase
        end
        if (wbReq && !wb_we_i) begin
            case (wb_adr_i)
                `KIP_ADR_KEY_LO: s_nxt.rdData = s_r.ident[31:0];
                `KIP_ADR_KEY_HI: s_nxt.rdData = {s_r.keyType, s_r.check, s_r.ident[47:32]};
                `KIP_ADR_HEAD: s_nxt.rdData = {8'h00, s_r.ledCmd, s_r.status};
                `KIP_ADR_IRQ_STAT: s_nxt.rdData = {28'h0000000, s_r.irqStat};
                `KIP_ADR_IRQ_EN: s_nxt.rdData = {28'h0000000, s_r.irqEn};
                default: s_nxt.rdData = 32'h00000000;
            endcase
        end

        // Sticky events, a new event wins over a clear
        s_nxt.irqStat = (s_r.irqStat & ~clrMask) | events;
        s_nxt.irqOut = |(s_nxt.irqStat & s_nxt.irqEn);
    end

    // State register
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '{keyType: 8'h00, ident: 48'h000000000000, check: 8'h00, status: 16'h0000,
                     ledCmd: `KIP_RST_CMD, headSel: key_id_process_image_pkg::HEAD_OWN,
                     busState: key_id_process_image_pkg::BUS_OFFLINE, blinkCnt: '0,
                     blinkPhase: 1'b0, flashPhase: 1'b0, headRed: 1'b0, headGreen: 1'b0,
                     busRed: 1'b1, busGreen: 1'b0, keyPrev: 1'b0, faultPrev: 1'b0,
                     irqStat: '0, irqEn: `KIP_RST_IRQ_EN, irqOut: 1'b0, ack: 1'b0,
                     rdData: 32'h00000000};
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign wb_dat_o = s_r.rdData;
    assign wb_ack_o = s_r.ack;
    assign irq = s_r.irqOut;
    assign imgKeyType = s_r.keyType;
    assign keyIdentByte = s_r.ident;
    assign imgKeyCheck = s_r.check;
    assign imgStatus = s_r.status;
    assign headLedRed = s_r.headRed;
    assign headLedGreen = s_r.headGreen;
    assign busStateIndicatorRed = s_r.busRed;
    assign busStateIndicatorGreen = s_r.busGreen;

    // Image and status checks
    a_zero_no_key: assert property (@(posedge sys_clk) disable iff (!nrst)
        cycleTick && !keyPresent |=> keyIdentByte == 48'h0 && imgKeyType == 8'h00 && imgKeyCheck == 8'h00)
        else $error("key fields not zero without key");
    a_ident_copy: assert property (@(posedge sys_clk) disable iff (!nrst)
        cycleTick && keyPresent && !keyReadError |=>
        keyIdentByte == $past(keyIdent) && imgKeyType == $past(keyFamily) && imgKeyCheck == $past(keyCheck))
        else $error("identifier not copied into image");
    a_fault_bit: assert property (@(posedge sys_clk) disable iff (!nrst)
        cycleTick |=> imgStatus[`KIP_STAT_LINK_FAULT] == $past(headLinkFault))
        else $error("link fault bit wrong");
    a_resv_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
        imgStatus[15:1] == 15'h0000)
        else $error("reserved status bits set");

    // Head lamp checks
    a_cmd_red: assert property (@(posedge sys_clk) disable iff (!nrst)
        s_r.ledCmd == `KIP_CMD_RED && !headLinkFault |=> headLedRed && !headLedGreen)
        else $error("red override not shown");
    a_cmd_green: assert property (@(posedge sys_clk) disable iff (!nrst)
        s_r.ledCmd == `KIP_CMD_GREEN && !headLinkFault |=> !headLedRed && headLedGreen)
        else $error("green override not shown");
    a_own_blink: assert property (@(posedge sys_clk) disable iff (!nrst)
        s_r.ledCmd != `KIP_CMD_RED && s_r.ledCmd != `KIP_CMD_GREEN && !headLinkFault
        && keyPresent && !keyReadError |=> !headLedRed && headLedGreen == $past(s_r.blinkPhase))
        else $error("own status green blink wrong");
    a_fault_block: assert property (@(posedge sys_clk) disable iff (!nrst)
        headLinkFault |=> headLedRed == headLedGreen && headLedRed == $past(s_r.blinkPhase))
        else $error("override not blocked by fault");

    // Bus-state indicator checks
    a_bus_active: assert property (@(posedge sys_clk) disable iff (!nrst)
        arActive |=> busStateIndicatorGreen && !busStateIndicatorRed)
        else $error("active connection not steady green");
    a_bus_idle: assert property (@(posedge sys_clk) disable iff (!nrst)
        !arActive && netConnected |=> busStateIndicatorGreen != busStateIndicatorRed
        && busStateIndicatorGreen == $past(s_r.blinkPhase))
        else $error("idle network not alternating");
    a_bus_offline: assert property (@(posedge sys_clk) disable iff (!nrst)
        !arActive && !netConnected |=> busStateIndicatorRed && !busStateIndicatorGreen)
        else $error("offline not steady red");

endmodule : key_id_process_image

/* test/io_ctrl_model.sv */
`timescale 1ns/1ns
module io_ctrl_model #(
    parameter int GAP = 8
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [7:0] cmdByte,
    input wire logic [7:0] imgKeyType,
    input wire logic [47:0] keyIdentByte,
    input wire logic [7:0] imgKeyCheck,
    output logic cycleTick,
    output logic cmdValid,
    output logic [7:0] headLampOverrideCmd,
    output logic keySeen
);
    int cnt;
    // One tick per communication cycle
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 0;
            cycleTick <= 1'b0;
        end else begin
            cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
            cycleTick <= (cnt == GAP - 1);
        end
    end
    // Output byte sent every cycle, scrambled outside its slot
    assign cmdValid = cycleTick;
    assign headLampOverrideCmd = cycleTick ? cmdByte : ~cmdByte;
    // All-zero key fields read as no key or error
    assign keySeen = |{imgKeyType, keyIdentByte, imgKeyCheck};
endmodule : io_ctrl_model

/* test/key_id_process_image_tb.sv */
`timescale 1ns/1ns
`include "key_id_process_image_defs.svh"
module key_id_process_image_tb;
    logic sys_clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq, cycleTick, cmdValid, keySeen;
    logic keyPresent, keyReadError, headLinkFault, netConnected, arActive;
    logic headLedRed, headLedGreen, busStateIndicatorRed, busStateIndicatorGreen;
    logic [7:0] wb_adr_i, keyFamily, keyCheck, cmdByte, headLampOverrideCmd, imgKeyType, imgKeyCheck;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [47:0] keyIdent, keyIdentByte;
    logic [15:0] imgStatus;
    logic [31:0] expQ[$];
    logic [7:0] cmds[6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'hFF, 8'h01};
    int mismatches, nChecks, seed, i, g;

    key_id_process_image #(.BLINK_HALF(4), .CNT_W(24)) key_id_process_image_i (.sys_clk(sys_clk), .nrst(nrst),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq), .cycleTick(cycleTick),
        .keyPresent(keyPresent), .keyReadError(keyReadError), .keyFamily(keyFamily), .keyIdent(keyIdent),
        .keyCheck(keyCheck), .headLinkFault(headLinkFault), .cmdValid(cmdValid),
        .headLampOverrideCmd(headLampOverrideCmd), .netConnected(netConnected), .arActive(arActive),
        .imgKeyType(imgKeyType), .keyIdentByte(keyIdentByte), .imgKeyCheck(imgKeyCheck), .imgStatus(imgStatus),
        .headLedRed(headLedRed), .headLedGreen(headLedGreen), .busStateIndicatorRed(busStateIndicatorRed),
        .busStateIndicatorGreen(busStateIndicatorGreen));
    io_ctrl_model #(.GAP(8)) io_ctrl_model_i (.sys_clk(sys_clk), .nrst(nrst), .cmdByte(cmdByte),
        .imgKeyType(imgKeyType), .keyIdentByte(keyIdentByte), .imgKeyCheck(imgKeyCheck), .cycleTick(cycleTick),
        .cmdValid(cmdValid), .headLampOverrideCmd(headLampOverrideCmd), .keySeen(keySeen));

    task automatic end_sim();
        $display("checks %0d mismatches %0d", nChecks, mismatches);
        if (mismatches == 0 && nChecks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        nChecks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Single classic cycle; for reads dat is the expected word
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= sel;
        if (!we) expQ.push_back(dat);
        // Wait for the answer; only the watchdog ends a hang
        do begin
            @(posedge sys_clk);
        end while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge sys_clk);
        #1;
    endtask : wb

    // Wait past the next cycle tick until the outputs settle
    task automatic tick();
        @(posedge sys_clk iff cycleTick === 1'b1);
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : tick

    // Read data checked against the oldest note
    always @(posedge sys_clk) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && expQ.size() > 0) chk(48'(wb_dat_o), 48'(expQ.pop_front()));
    end

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        end_sim();
    end

    initial begin
        {nrst, wb_cyc_i, wb_stb_i, wb_we_i, keyPresent, keyReadError, headLinkFault, netConnected, arActive} = '0;
        {wb_adr_i, wb_sel_i, wb_dat_i, keyFamily, keyIdent, keyCheck, cmdByte} = '0;
        seed = 41243;
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b1;
        tick();
        chk(48'(keySeen), 48'h0);
        wb(1'b0, 8'h20, 32'h0, 4'hF);
        wb(1'b1, `KIP_ADR_IRQ_EN, 32'h1, 4'h0);
        wb(1'b0, `KIP_ADR_IRQ_EN, 32'h0, 4'hF);
        // Event masked, then enabled, then cleared
        @(posedge sys_clk);
        keyPresent <= 1'b1;
        tick();
        chk(48'(irq), 48'h0);
        wb(1'b1, `KIP_ADR_IRQ_EN, 32'h1, 4'hF);
        chk(48'(irq), 48'h1);
        wb(1'b1, `KIP_ADR_IRQ_CLR, 32'h1, 4'hF);
        chk(48'(irq), 48'h0);
        wb(1'b0, `KIP_ADR_IRQ_CLR, 32'h0, 4'hF);
        // Random keys, link fault on odd passes
        for (i = 0; i < 3; i++) begin
            @(posedge sys_clk);
            keyFamily <= 8'($random(seed));
            keyIdent <= {16'($random(seed)), 32'($random(seed))};
            keyCheck <= 8'($random(seed));
            headLinkFault <= i[0];
            tick();
            chk(keyIdentByte, keyIdent);
            chk(48'({imgKeyType, imgKeyCheck}), 48'({keyFamily, keyCheck}));
            chk(48'(imgStatus), 48'(i[0]));
            wb(1'b0, `KIP_ADR_KEY_HI, {keyFamily, keyCheck, keyIdent[47:32]}, 4'hF);
            wb(1'b0, `KIP_ADR_KEY_LO, keyIdent[31:0], 4'hF);
        end
        // Head lamp under each override value, last one under fault
        foreach (cmds[k]) begin
            @(posedge sys_clk);
            cmdByte <= cmds[k];
            headLinkFault <= (k == 5);
            tick();
            g = 0;
            repeat (8) begin
                @(posedge sys_clk);
                #1;
                g += headLedGreen;
                if (k == 5) chk(48'(headLedRed ^ headLedGreen), 48'h0);
                else if (cmds[k] == 8'h01) chk(48'({headLedRed, headLedGreen}), 48'h2);
                else if (cmds[k] == 8'h02) chk(48'({headLedRed, headLedGreen}), 48'h1);
                else chk(48'(headLedRed), 48'h0);
            end
            if (k != 5 && !(cmds[k] inside {8'h01, 8'h02})) chk(48'(g > 0 && g < 8), 48'h1);
        end
        // Lamp command and fault bit, then the sticky events: fault rising and command received
        wb(1'b0, `KIP_ADR_HEAD, 32'h00010001, 4'hF);
        wb(1'b0, `KIP_ADR_IRQ_STAT, 32'h0000000C, 4'hF);
        @(posedge sys_clk);
        keyReadError <= 1'b1;
        tick();
        chk(48'(keySeen), 48'h0);
        // Bus indicator: active, networked only, offline
        for (i = 0; i < 3; i++) begin
            @(posedge sys_clk);
            netConnected <= (i < 2);
            arActive <= (i == 0);
            repeat (2) @(posedge sys_clk);
            g = 0;
            repeat (8) begin
                @(posedge sys_clk);
                #1;
                g += busStateIndicatorGreen;
                if (i == 1) chk(48'(busStateIndicatorRed ^ busStateIndicatorGreen), 48'h1);
                else chk(48'({busStateIndicatorRed, busStateIndicatorGreen}), (i == 0) ? 48'h1 : 48'h2);
            end
            if (i == 1) chk(48'(g > 0 && g < 8), 48'h1);
        end
        end_sim();
    end
endmodule : key_id_process_image_tb
